// File: bench/bus_side.sv
// Arbiter and system bus model facing the DMA sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_side (
	// Clock, reset and master side
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        bus_req,
	input wire logic        master_transfer_start,
	input wire logic        m_chan,
	input wire logic [31:0] m_addr,
	// Arbiter and termination
	output logic            bus_grant,
	output logic            m_term_ok,
	output logic            m_term_err
);
	int          lat = 1, err_at = 0, np = 0, nt = 0, reqs = 0, cnt = 0;
	logic        req_q = 0;
	logic [31:0] la[$];
	logic        lc[$];
	always @(posedge mclk)
	begin
		m_term_ok <= 0;
		m_term_err <= 0;
		bus_grant <= bus_req && !reset;
		req_q <= bus_req;
		if (bus_req && !req_q)
			reqs++;
		if (master_transfer_start)
		begin
			np++;
			la.push_back(m_addr);
			lc.push_back(m_chan);
			cnt = lat;
		end
		else if (cnt == 1)
		begin
			nt++;
			cnt = 0;
			if (np == err_at)
				m_term_err <= 1;
			else
				m_term_ok <= 1;
		end
		else if (cnt > 1)
			cnt--;
	end
endmodule // bus_side
`default_nettype wire

// File: bench/dma_channel_sequencer_bench.sv
// Self-checking bench for the DMA sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dma_seq_map.vh"
module dma_channel_sequencer_bench;
	localparam logic [31:0] ST = 32'h1 << `CTL_START, OS = 32'h1 << `CTL_ONESHOT;
	localparam logic [31:0] EX = 32'h1 << `CTL_EXTSEL, SG = 32'h1 << `CTL_SINGLE;
	localparam logic [31:0] SS = 32'h1 << `CTL_SSTEP, DS = 32'h1 << `CTL_DSTEP;
	localparam logic [31:0] IE = 32'h1 << `CTL_INTEN, DW = 32'h2 << `CTL_DW_LO;
	localparam logic [31:0] BL = 32'h1 << `CTL_BL_LO;
	logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, iack = 0;
	logic        module_select = 0, vector_output_en = 0, perr;
	logic        pready, pslverr, bus_req, bus_grant, master_transfer_start, m_rw;
	logic        m_chan, m_term_ok, m_term_err, vec_valid;
	logic [1:0]  transfer_request_pin = 2'h0, m_size, chan_irq;
	logic [7:0]  paddr = 8'h00, vec_data;
	logic [31:0] pwdata = 32'h0, rd, prdata, m_addr;
	logic [31:0] exp3[6] = '{32'h200, 32'h300, 32'h302, 32'h204, 32'h304, 32'h306};
	int          errors = 0, checked = 0, cyc = 0;
	dma_channel_sequencer dma_channel_sequencer_inst (.*);
	bus_side bus_side_inst (.*);
	always #20 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			errors++;
			wrap_up;
		end
	end
	// ----------------
	// Tasks
	// ----------------
	task wrap_up;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge mclk);
		penable <= 1;
		do
			@(posedge mclk);
		while (pready !== 1);
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task setup(input logic [7:0] b, input logic [31:0] s, d, c, t);
		xfer(1, b + `OFS_SRC, s);
		xfer(1, b + `OFS_DST, d);
		xfer(1, b + `OFS_CNT, c);
		xfer(1, b + `OFS_CTRL, t);
	endtask
	task fresh(input int l, input int e);
		bus_side_inst.lat = l;
		bus_side_inst.err_at = e;
		bus_side_inst.np = 0;
		bus_side_inst.nt = 0;
		bus_side_inst.reqs = 0;
		bus_side_inst.la.delete();
		bus_side_inst.lc.delete();
	endtask
	task waitt(input int n);
		while (bus_side_inst.nt < n)
			@(posedge mclk);
		repeat (3) @(posedge mclk);
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		repeat (6) @(posedge mclk);
		reset <= 0;
		xfer(0, `OFS_CTRL, 0);
		chk(rd, 0);
		xfer(0, `OFS_VEC, 0);
		chk(rd, `RST_VEC);
		xfer(0, 8'h44, 0);
		chk(perr, 1);
		xfer(0, 8'h02, 0);
		chk(perr, 1);
		fresh(4, 0);
		setup(0, 32'h100, 0, 32'h8, ST | OS | SG | SS);
		xfer(0, `OFS_STAT, 0);
		chk(rd[2:1], 2'h2);
		xfer(0, `OFS_STAT, 0);
		chk(rd[2:1], 2'h1);
		waitt(1);
		repeat (20) @(posedge mclk);
		chk(bus_side_inst.np, 1);
		chk(m_addr, 32'h100);
		chk(m_rw, 0);
		xfer(1, `OFS_CTRL, ST | OS | SG | SS);
		waitt(2);
		xfer(0, `OFS_CNT, 0);
		chk(rd, 0);
		xfer(0, `OFS_SRC, 0);
		chk(rd, 32'h108);
		xfer(0, `OFS_STAT, 0);
		chk(rd[6:0], 1);
		xfer(1, `OFS_STAT, 1);
		fresh(1, 0);
		setup(0, 32'h200, 32'h300, 32'h8, ST | SS | DS | DW | IE);
		waitt(6);
		for (int i = 0; i < 6; i++)
			chk(bus_side_inst.la[i], exp3[i]);
		chk(bus_side_inst.reqs, 1);
		chk(m_size, 2'h2);
		chk(chan_irq, 1);
		xfer(0, `OFS_DST, 0);
		chk(rd, 32'h308);
		xfer(1, `OFS_STAT, 1);
		xfer(0, `OFS_STAT, 0);
		chk(rd, 0);
		chk(chan_irq, 0);
		fresh(1, 0);
		setup(0, 32'h400, 0, 32'h204, ST | SG | BL);
		waitt(129);
		chk(bus_side_inst.reqs, 2);
		xfer(0, `OFS_STAT, 0);
		chk(rd[6:0], 1);
		xfer(1, `OFS_STAT, 1);
		for (int i = 0; i < 3; i++)
		begin
			fresh(1, (i == 2) ? 2 : 1);
			setup(0, 32'h200, 32'h300, 32'h8, ST | ((i == 0) ? SG : 0));
			waitt((i == 2) ? 2 : 1);
			xfer(0, `OFS_STAT, 0);
			chk(rd[6:0], (i == 2) ? 7'h11 : 7'h21);
			xfer(1, `OFS_STAT, 1);
		end
		for (int i = 0; i < 2; i++)
		begin
			fresh(1, 0);
			setup(0, i ? 32'h101 : 32'h100, 0, i ? 4 : 6, ST | SG | IE);
			repeat (10) @(posedge mclk);
			chk(bus_side_inst.np, 0);
			xfer(0, `OFS_STAT, 0);
			chk(rd[6], 1);
			chk(chan_irq, 1);
			xfer(1, `OFS_CTRL, 0);
			xfer(1, `OFS_STAT, 1);
		end
		xfer(1, `OFS_VEC, 32'hA5);
		for (int i = 0; i < 8; i++)
		begin
			{iack, module_select, vector_output_en} <= i[2:0];
			repeat (2) @(posedge mclk);
			chk(vec_valid, i == 7);
		end
		chk(vec_data, 8'hA5);
		for (int i = 0; i < 2; i++)
		begin
			fresh(1, 0);
			setup(0, 32'h400, 0, 32'h4, OS | EX | SG | (i ? 0 : BL));
			setup(`OFS_CH1_BASE, 32'h500, 0, 32'h4, OS | EX | SG);
			transfer_request_pin <= 2'h3;
			waitt(2);
			chk(bus_side_inst.lc[0], i == 0);
			transfer_request_pin <= 2'h0;
			xfer(1, `OFS_STAT, 1);
			xfer(1, `OFS_CH1_BASE + `OFS_STAT, 1);
		end
		wrap_up;
	end
endmodule // dma_channel_sequencer_bench
`default_nettype wire

// File: bench/dma_channel_sequencer_properties.sv
// Concurrent checks on the DMA sequencer ports
`timescale 1ns/1ns
`default_nettype none
module dma_channel_sequencer_properties (
	// Clock, reset and register bus
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  paddr,
	// Internal bus
	input wire logic        bus_req,
	input wire logic        bus_grant,
	input wire logic        master_transfer_start,
	input wire logic        m_rw,
	input wire logic        m_term_ok,
	input wire logic        m_term_err,
	input wire logic [31:0] m_addr,
	// Vector acknowledge
	input wire logic        iack,
	input wire logic        module_select,
	input wire logic        vector_output_en,
	input wire logic        vec_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// ----------------
	// Sequences
	// ----------------
	sequence s_setup; psel && !penable; endsequence
	sequence s_granted; bus_req && $rose(bus_grant); endsequence
	sequence s_ack; iack && module_select && vector_output_en; endsequence
	// ----------------
	// Properties
	// ----------------
	property p_zero_wait; s_setup |=> pready; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("setup not answered");
	property p_bad_addr; s_setup ##0 (paddr[1:0] != 2'h0) |=> pready && pslverr; endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unaligned not refused");
	property p_vector; s_ack |=> vec_valid; endproperty
	a_vector: assert property (p_vector) else $error("vector not returned");
	property p_no_vector; !(iack && module_select && vector_output_en) |=> !vec_valid; endproperty
	a_no_vector: assert property (p_no_vector) else $error("vector without select");
	property p_pulse; master_transfer_start |=> !master_transfer_start; endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_idle_clock; (m_term_ok || m_term_err) |=> !master_transfer_start; endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("no idle clock");
	property p_err_stop; m_term_err |=> (!master_transfer_start) [*8]; endproperty
	a_err_stop: assert property (p_err_stop) else $error("cycle after bus error");
	property p_req_gap; $fell(bus_req) |=> !bus_req; endproperty
	a_req_gap: assert property (p_req_gap) else $error("request back too soon");
	property p_addr_hold; !master_transfer_start |-> $stable(m_addr) && $stable(m_rw); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	property p_grant_start; s_granted |-> ##[1:3] master_transfer_start; endproperty
	a_grant_start: assert property (p_grant_start) else $error("grant unused");
endmodule // dma_channel_sequencer_properties
bind dma_channel_sequencer dma_channel_sequencer_properties dma_channel_sequencer_properties_inst (.*);
`default_nettype wire

// File: common/dma_seq_map.vh
// Register map, field positions, reset values and timing of the DMA sequencer
`ifndef DMA_SEQ_MAP_VH
`define DMA_SEQ_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_SRC       8'h00
`define OFS_DST       8'h04
`define OFS_CNT       8'h08
`define OFS_CTRL      8'h0C
`define OFS_STAT      8'h10
`define OFS_CH1_BASE  8'h20
`define OFS_VEC       8'h40

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_START     0
`define CTL_ONESHOT   1
`define CTL_EXTSEL    2
`define CTL_SINGLE    3
`define CTL_SDIR      4
`define CTL_SSTEP     5
`define CTL_DSTEP     6
`define CTL_SW_LO     7
`define CTL_DW_LO     9
`define CTL_BL_LO     11
`define CTL_AALIGN    14
`define CTL_INTEN     15

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STS_DONE      0
`define STS_ACTIVE    1
`define STS_PEND      2
`define STS_DFAULT    4
`define STS_SFAULT    5
`define STS_CFAULT    6

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_PTR       32'h00000000
`define RST_CNT       16'h0000
`define RST_CTRL      16'h0000
`define RST_VEC       8'h0F
`define BL_BASE       16'h0100
`define GAP_CYCLES    1

`endif

// File: logic/dma_channel_sequencer.v
// Two-channel DMA sequencer with APB register slave
// Notes on behaviour
// - One-shot mode: exactly one complete transfer per received request.
// - Continuous mode runs until count zero, bus error, or done written.
// - Burst limit zero keeps bus request until count zero, bus error, one-shot end or done write.
// - Nonzero burst limit drops bus request on last transfer before boundary.
// - Request returns as soon as possible, after at least one cycle off.
// - Vector returned on acknowledge only with module select and output enable.
// - Single mode: clean request sets pending; selection in idle, before grant, sets active, clears pending.
// - Single mode drives source pointer and direction bit, one cycle per transfer.
// - Count drops per write phase (dual) or any phase (single); zero sets done.
// - Bus error on single access or dual read sets source fault and done.
// - Dual read drives source pointer, steps it if enabled, then writes.
// - Dual write drives destination, steps, decrements, ends or repeats.
// - At burst multiple request drops until cycle ends; idle clock before start.
// - Bus error on dual write sets destination fault and done, stops.
// - Request is start bit or pin with external select; start clears at begin.
// - Misaligned pointers block transfer and set setup fault.
// - Count inconsistent with source or destination size sets setup fault.
// - Setup fault may interrupt; auto align skips the aligned register check.
// - Dual transfer moves the larger of source and destination sizes.
// - Pointers update only after a successful address phase.
// - Channel 0 wins unless only channel 1 has burst limit zero.
// - Register writes never blocked; control changes act immediately.
// - Burst code 000 off; 001 to 111 select 512 to 32768 bytes.
// - Size code 00 long, 01 byte, 10 word, 11 line; step 4,1,2,16.
// - Writing one to done resets channel state and aborts; zero ignored.
`timescale 1ns/1ns
`default_nettype none
`include "dma_seq_map.vh"

module dma_channel_sequencer #(
	parameter VEC_RESET = `RST_VEC	// Arbitrary vector reset value
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        reset,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// External request pins
	input  wire [1:0]  transfer_request_pin,
	// Internal bus master side
	output reg         bus_req,
	input  wire        bus_grant,
	output reg         master_transfer_start,
	output reg  [31:0] m_addr,
	output reg         m_rw,
	output reg  [1:0]  m_size,
	output reg         m_chan,
	input  wire        m_term_ok,
	input  wire        m_term_err,
	// Interrupt acknowledge and interrupts
	input  wire        iack,
	input  wire        module_select,
	input  wire        vector_output_en,
	output reg  [7:0]  vec_data,
	output reg         vec_valid,
	output reg  [1:0]  chan_irq
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_REQ   = 3'h1;
	localparam [2:0] S_ISSUE = 3'h2;
	localparam [2:0] S_WAIT  = 3'h3;
	localparam [2:0] S_GAP   = 3'h4;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function [2:0] size_shift;
		input [1:0] code;
		begin
			case (code)
				2'h0:    size_shift = 3'h2;
				2'h1:    size_shift = 3'h0;
				2'h2:    size_shift = 3'h1;
				default: size_shift = 3'h4;
			endcase
		end
	endfunction

	function [4:0] size_bytes;
		input [1:0] code;
		begin
			size_bytes = 5'h01 << size_shift(code);
		end
	endfunction

	function [3:0] size_mask;
		input [1:0] code;
		begin
			size_mask = 4'hF >> (3'h4 - size_shift(code));
		end
	endfunction

	function at_boundary;
		input [2:0]  code;
		input [15:0] cnt;
		reg   [15:0] msk;
		begin
			msk = (`BL_BASE << code) - 16'h0001;
			at_boundary = (code != 3'h0) && ((cnt & msk) == 16'h0000);
		end
	endfunction

	function [4:0] n_reads;
		input [1:0] my_w;
		input [1:0] other_w;
		reg   [2:0] a;
		reg   [2:0] b;
		begin
			a = size_shift(my_w);
			b = size_shift(other_w);
			n_reads = (b > a) ? (5'h01 << (b - a)) : 5'h01;
		end
	endfunction

	function cfg_bad;
		input [15:0] ctl;
		input [31:0] sp;
		input [31:0] dp;
		input [15:0] cnt;
		reg   [3:0]  ms;
		reg   [3:0]  md;
		reg          al_s;
		reg          al_d;
		reg          sgl;
		begin
			ms   = size_mask(ctl[`CTL_SW_LO+1:`CTL_SW_LO]);
			md   = size_mask(ctl[`CTL_DW_LO+1:`CTL_DW_LO]);
			sgl  = ctl[`CTL_SINGLE];
			al_s = ctl[`CTL_AALIGN] && (ms >= md);
			al_d = ctl[`CTL_AALIGN] && !al_s && !sgl;
			cfg_bad = (!al_s && (((sp[3:0] & ms) != 4'h0) || ((cnt[3:0] & ms) != 4'h0)))
				|| (!sgl && !al_d && (((dp[3:0] & md) != 4'h0)
				|| ((cnt[3:0] & md) != 4'h0)));
		end
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [31:0] src_q [0:1];
	reg [31:0] dst_q [0:1];
	reg [15:0] cnt_q [0:1];
	reg [15:0] ctrl_q [0:1];
	reg [7:0]  vec_q;
	reg [1:0]  start_q;
	reg [1:0]  done_q;
	reg [1:0]  act_q;
	reg [1:0]  pend_q;
	reg [1:0]  sflt_q;
	reg [1:0]  dflt_q;
	reg [1:0]  cflt_q;
	reg [2:0]  state_q;
	reg        ch_q;
	reg        wph_q;
	reg [4:0]  left_q;
	reg [31:0] rd_d;
	reg        err_d;
	reg        sel_d;
	reg        any_d;
	integer    i;

	// ----------------------------------------------------------------
	// Decode of current channel and bus write
	// ----------------------------------------------------------------
	wire [15:0] cc     = ctrl_q[ch_q];
	wire [15:0] ccnt   = cnt_q[ch_q];
	wire [1:0]  sw     = cc[`CTL_SW_LO+1:`CTL_SW_LO];
	wire [1:0]  dw     = cc[`CTL_DW_LO+1:`CTL_DW_LO];
	wire        sgl    = cc[`CTL_SINGLE];
	wire        wr_en  = psel & penable & pwrite & pready;
	wire        rch    = paddr[5];
	wire [7:0]  roff   = {3'h0, paddr[4:0]};
	wire        in_ch  = (paddr[7:6] == 2'h0);
	wire        last   = sgl | (wph_q & (left_q == 5'h01));
	wire [4:0]  stepb  = (sgl | !wph_q) ? size_bytes(sw) : size_bytes(dw);
	wire [15:0] ncnt   = ccnt - {11'h000, stepb};
	wire [1:0]  done_wr;
	wire [1:0]  req_evt;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_req
			assign done_wr[g] = wr_en && in_ch && (rch == g) && (roff == `OFS_STAT)
				&& pwdata[`STS_DONE];
			assign req_evt[g] = start_q[g]
				| (ctrl_q[g][`CTL_EXTSEL] & transfer_request_pin[g]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration between channels
	// ----------------------------------------------------------------
	wire [1:0] cand   = pend_q | (act_q & ~done_q);
	wire       bl0_z  = (ctrl_q[0][`CTL_BL_LO+2:`CTL_BL_LO] == 3'h0);
	wire       bl1_z  = (ctrl_q[1][`CTL_BL_LO+2:`CTL_BL_LO] == 3'h0);
	wire       pick1  = cand[1] && (!cand[0] || (bl1_z && !bl0_z));

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @*
	begin
		rd_d  = 32'h00000000;
		err_d = 1'b0;
		sel_d = rch;
		if (paddr == `OFS_VEC)
			rd_d = {24'h000000, vec_q};
		else if (!in_ch || paddr[1:0] != 2'h0)
			err_d = 1'b1;
		else if (roff == `OFS_SRC)
			rd_d = src_q[sel_d];
		else if (roff == `OFS_DST)
			rd_d = dst_q[sel_d];
		else if (roff == `OFS_CNT)
			rd_d = {16'h0000, cnt_q[sel_d]};
		else if (roff == `OFS_CTRL)
			rd_d = {16'h0000, ctrl_q[sel_d]};
		else if (roff == `OFS_STAT)
			rd_d = {25'h0000000, cflt_q[sel_d], sflt_q[sel_d], dflt_q[sel_d], 1'b0,
				pend_q[sel_d], act_q[sel_d], done_q[sel_d]};
		else
			err_d = 1'b1;
	end

	// ----------------------------------------------------------------
	// Sequential logic
	// ----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (reset)
		begin
			for (i = 0; i < 2; i = i + 1)
			begin
				src_q[i]  <= `RST_PTR;
				dst_q[i]  <= `RST_PTR;
				cnt_q[i]  <= `RST_CNT;
				ctrl_q[i] <= `RST_CTRL;
			end
			vec_q                 <= VEC_RESET;
			start_q               <= 2'h0;
			done_q                <= 2'h0;
			act_q                 <= 2'h0;
			pend_q                <= 2'h0;
			sflt_q                <= 2'h0;
			dflt_q                <= 2'h0;
			cflt_q                <= 2'h0;
			state_q               <= S_IDLE;
			ch_q                  <= 1'b0;
			wph_q                 <= 1'b0;
			left_q                <= 5'h00;
			prdata                <= 32'h00000000;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			bus_req               <= 1'b0;
			master_transfer_start <= 1'b0;
			m_addr                <= 32'h00000000;
			m_rw                  <= 1'b1;
			m_size                <= 2'h0;
			m_chan                <= 1'b0;
			vec_data              <= 8'h00;
			vec_valid             <= 1'b0;
			chan_irq              <= 2'h0;
		end
		else
		begin
			// APB answer, ready in the access phase
			pready  <= psel & ~penable;
			prdata  <= rd_d;
			pslverr <= psel & ~penable & err_d;

			// Done write clears state first so that hardware sets win
			for (i = 0; i < 2; i = i + 1)
			begin
				if (done_wr[i])
				begin
					done_q[i]  <= 1'b0;
					act_q[i]   <= 1'b0;
					pend_q[i]  <= 1'b0;
					sflt_q[i]  <= 1'b0;
					dflt_q[i]  <= 1'b0;
					cflt_q[i]  <= 1'b0;
					start_q[i] <= 1'b0;
				end
				else if (req_evt[i] && !act_q[i] && !pend_q[i] && !done_q[i])
				begin
					if (cfg_bad(ctrl_q[i], src_q[i], dst_q[i], cnt_q[i]))
					begin
						cflt_q[i]  <= 1'b1;
						done_q[i]  <= 1'b1;
						start_q[i] <= 1'b0;
					end
					else
						pend_q[i] <= 1'b1;
				end
			end

			// Transfer engine
			master_transfer_start <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					bus_req <= 1'b0;
					if (cand != 2'h0)
					begin
						ch_q                  <= pick1;
						act_q[pick1]          <= 1'b1;
						pend_q[pick1]         <= 1'b0;
						start_q[pick1]        <= 1'b0;
						wph_q                 <= 1'b0;
						left_q                <= n_reads(ctrl_q[pick1][`CTL_SW_LO+1:`CTL_SW_LO],
							ctrl_q[pick1][`CTL_DW_LO+1:`CTL_DW_LO]);
						bus_req               <= 1'b1;
						state_q               <= S_REQ;
					end
				end
				S_REQ:
				begin
					if (bus_grant)
						state_q <= S_ISSUE;
				end
				S_ISSUE:
				begin
					master_transfer_start <= 1'b1;
					m_chan                <= ch_q;
					m_addr                <= (sgl | !wph_q) ? src_q[ch_q] : dst_q[ch_q];
					m_rw                  <= sgl ? cc[`CTL_SDIR] : !wph_q;
					m_size                <= (sgl | !wph_q) ? sw : dw;
					if (last && at_boundary(cc[`CTL_BL_LO+2:`CTL_BL_LO], ncnt))
						bus_req <= 1'b0;
					state_q <= S_WAIT;
				end
				S_WAIT:
				begin
					if (m_term_err)
					begin
						if (sgl | !wph_q)
							sflt_q[ch_q] <= 1'b1;
						else
							dflt_q[ch_q] <= 1'b1;
						done_q[ch_q] <= 1'b1;
						act_q[ch_q]  <= 1'b0;
						bus_req      <= 1'b0;
						state_q      <= S_GAP;
					end
					else if (m_term_ok)
					begin
						// Pointer stepping after a successful address phase
						if ((sgl | !wph_q) && cc[`CTL_SSTEP])
							src_q[ch_q] <= src_q[ch_q] + {27'h0000000, stepb};
						if (!sgl && wph_q && cc[`CTL_DSTEP])
							dst_q[ch_q] <= dst_q[ch_q] + {27'h0000000, stepb};
						if (sgl | wph_q)
							cnt_q[ch_q] <= ncnt;
						if (!last)
						begin
							if (!sgl && !wph_q && left_q == 5'h01)
							begin
								wph_q  <= 1'b1;
								left_q <= n_reads(dw, sw);
							end
							else
								left_q <= left_q - 5'h01;
							state_q <= bus_grant ? S_ISSUE : S_REQ;
						end
						else if (ncnt == 16'h0000)
						begin
							done_q[ch_q] <= 1'b1;
							act_q[ch_q]  <= 1'b0;
							bus_req      <= 1'b0;
							state_q      <= S_GAP;
						end
						else if (cc[`CTL_ONESHOT])
						begin
							act_q[ch_q] <= 1'b0;
							bus_req     <= 1'b0;
							state_q     <= S_GAP;
						end
						else if (!bus_req)
							state_q <= S_GAP;
						else
						begin
							wph_q   <= 1'b0;
							left_q  <= n_reads(sw, dw);
							state_q <= bus_grant ? S_ISSUE : S_REQ;
						end
					end
				end
				S_GAP:
				begin
					bus_req <= 1'b0;
					state_q <= S_IDLE;
				end
				default:
				begin
					bus_req <= 1'b0;
					state_q <= S_IDLE;
				end
			endcase

			// Abort of the running channel
			if (done_wr[ch_q] && state_q != S_IDLE)
			begin
				bus_req               <= 1'b0;
				master_transfer_start <= 1'b0;
				state_q               <= S_GAP;
			end

			// Register writes, never blocked
			if (wr_en && paddr == `OFS_VEC)
				vec_q <= pwdata[7:0];
			else if (wr_en && in_ch && roff == `OFS_SRC)
				src_q[rch] <= pwdata;
			else if (wr_en && in_ch && roff == `OFS_DST)
				dst_q[rch] <= pwdata;
			else if (wr_en && in_ch && roff == `OFS_CNT)
				cnt_q[rch] <= pwdata[15:0];
			else if (wr_en && in_ch && roff == `OFS_CTRL)
			begin
				ctrl_q[rch] <= {pwdata[15:1], 1'b0};
				if (pwdata[`CTL_START])
					start_q[rch] <= 1'b1;
			end

			// Vector supply on acknowledge
			vec_valid <= iack & module_select & vector_output_en;
			vec_data  <= (iack & module_select & vector_output_en) ? vec_q : 8'h00;

			// Interrupt level follows done
			for (i = 0; i < 2; i = i + 1)
				chan_irq[i] <= ctrl_q[i][`CTL_INTEN] & done_q[i];
		end
	end

endmodule // dma_channel_sequencer
`default_nettype wire
